// >>> common/limit_pkg.sv
// Constants and types for the drive limit prohibition logic
package limit_pkg;
  localparam int NUM_INPUTS = 8;
  localparam int ADDR_W     = 12;
  // Register byte offsets
  localparam logic [11:0] OFS_SEL_BASE = 12'h000;
  localparam logic [11:0] OFS_CTRL     = 12'h020;
  localparam logic [11:0] OFS_ESTOP    = 12'h024;
  localparam logic [11:0] OFS_STATUS   = 12'h028;
  localparam logic [3:0]  IDX_SEL_LAST = 4'h7;
  localparam logic [3:0]  IDX_CTRL     = 4'h8;
  localparam logic [3:0]  IDX_ESTOP    = 4'h9;
  localparam logic [3:0]  IDX_STATUS   = 4'ha;
  // Reset values
  localparam logic [31:0] SEL_TWO_RST   = 32'h0081_8181;
  localparam logic [31:0] SEL_THREE_RST = 32'h0082_8282;
  localparam logic [31:0] SEL_OTHER_RST = 32'h0000_0000;
  localparam int          SEL_TWO_IDX   = 1;
  localparam int          SEL_THREE_IDX = 2;
  // Selector fields: one byte per control mode, bit 7 = normally closed
  localparam int FLD_W    = 8;
  localparam int NC_BIT   = 7;
  localparam logic [6:0] FN_FWD_LIMIT = 7'h01;
  localparam logic [6:0] FN_REV_LIMIT = 7'h02;
  localparam logic [1:0] MODE_POS    = 2'h0;
  localparam logic [1:0] MODE_SPEED  = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;
  // Control register fields
  localparam int CTRL_RESP_LSB = 0;
  localparam int CTRL_STOP_LSB = 2;
  localparam int CTRL_MON_BIT  = 4;
  localparam int STAT_ALARM_BIT = 2;
  // Limit response select values
  localparam logic [1:0] RESP_ENABLED = 2'h0;
  localparam logic [1:0] RESP_IGNORE  = 2'h1;
  localparam logic [1:0] RESP_ALARM   = 2'h2;
  // Limit stop method select values
  localparam logic [1:0] STOP_DYN_BRAKE = 2'h0;
  localparam logic [1:0] STOP_FREE_RUN  = 2'h1;
  localparam logic [1:0] STOP_ESTOP     = 2'h2;
  // Emergency stop torque, percent
  localparam logic [9:0] ESTOP_TORQUE_MAX = 10'h1f4;
  localparam logic [9:0] ESTOP_TORQUE_USE_NORMAL = 10'h000;
  // Deceleration ends at or below this speed, r/min
  localparam logic [15:0] STOP_SPEED_RPM = 16'h001e;
  // Drive prohibition alarm 38.0 (38 decimal)
  localparam logic [7:0] ALARM_MAIN = 8'h26;
  localparam logic [3:0] ALARM_SUB  = 4'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_DECEL, ST_HOLD} stop_state_t;
endpackage

// >>> rtl/drive_limit_prohibit_logic.sv
// Forward/reverse limit prohibition, stop sequencing and APB registers
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Modes 0, 2: both limits off stops the motor
// - Mode 0: forward open blocks forward only
// - Mode 0: reverse open blocks reverse only
// - Mode 0: shorted input means normal status
// - Blocked direction decelerates by chosen method
// - Mode 0: both open raises alarm 38.0
// - Mode 1: limit inputs ignored for motion
// - Mode 2: either open raises alarm 38.0
// - Selectors two/three reset to limit NC
// - Mode 1: reflect setting gates monitor
// - Limit emergency stop uses own torque
// - Eight selectors choose pin function, logic
// - Method 0 brake, 1 free-run, 2 estop
// - Deceleration ends at 30 r/min
// - Estop torque 0..500, zero uses normal
module drive_limit_prohibit_logic (
  input  wire logic        pclk,               // APB clock
  input  wire logic        presetn,            // Async reset, active low
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB enable
  input  wire logic        pwrite,             // APB write
  input  wire logic [11:0] paddr,              // APB byte address
  input  wire logic [31:0] pwdata,             // APB write data
  input  wire logic [3:0]  pstrb,              // APB byte strobes
  output var  logic [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output var  logic        pslverr,            // APB error
  input  wire logic [7:0]  input_pins,         // Raw pins, 1 = contact shorted
  input  wire logic [1:0]  control_mode,       // 0 pos, 1 speed, 2 torque
  input  wire logic [15:0] motor_speed,        // Speed magnitude, r/min
  input  wire logic [9:0]  normal_torque_limit, // Normal torque limit, percent
  input  wire logic        alarm_clear,        // Pulse clears the alarm
  output var  logic        fwd_permit,         // Forward motion allowed
  output var  logic        rev_permit,         // Reverse motion allowed
  output var  logic        dyn_brake,          // Dynamic brake active
  output var  logic        free_run,           // Drive output off, coasting
  output var  logic        estop_active,       // Controlled emergency stop
  output var  logic        err_counter_clear,  // Clear position error counter
  output var  logic [9:0]  torque_limit,       // Torque limit in use
  output var  logic        alarm_active,       // Drive prohibition alarm
  output var  logic [7:0]  alarm_main,         // Alarm number
  output var  logic [3:0]  alarm_sub,          // Alarm sub-number
  output var  logic [7:0]  io_monitor          // Network I/O monitor bits
);
  localparam int N = limit_pkg::NUM_INPUTS;

  logic [31:0] selector [N];
  logic [1:0]  resp_sel;
  logic [1:0]  stop_sel;
  logic        mon_reflect;
  logic [9:0]  estop_torque;
  logic [7:0]  pins;
  logic [7:0]  code [N];
  logic [7:0]  is_limit;
  logic        fwd_act;
  logic        rev_act;
  logic        fwd_blk;
  logic        rev_blk;
  logic        alarm_set;
  logic        stop_req;
  logic        slow;
  limit_pkg::stop_state_t state;
  limit_pkg::stop_state_t next_state;
  logic [3:0]  idx;
  logic        addr_ok;
  logic        wr_en;
  logic        setup;
  logic [31:0] rd_val;
  logic [31:0] wmask;

  assign pready = 1'b1;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_sync
      sync_bit u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (input_pins[g]),
        .q       (pins[g])
      );
    end
  endgenerate

  // APB decode; slave always answers without wait states
  assign idx     = paddr[5:2];
  assign addr_ok = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                   (idx <= limit_pkg::IDX_STATUS);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign setup   = psel && !penable;

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{pstrb[b]}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < N; i++) begin
        if (i == limit_pkg::SEL_TWO_IDX) begin
          selector[i] <= limit_pkg::SEL_TWO_RST;
        end else if (i == limit_pkg::SEL_THREE_IDX) begin
          selector[i] <= limit_pkg::SEL_THREE_RST;
        end else begin
          selector[i] <= limit_pkg::SEL_OTHER_RST;
        end
      end
    end else if (wr_en && idx <= limit_pkg::IDX_SEL_LAST) begin
      selector[idx[2:0]] <= (selector[idx[2:0]] & ~wmask) | (pwdata & wmask);
    end
  end

  // Control register; default ignores limits until software enables them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_sel    <= limit_pkg::RESP_IGNORE;
      stop_sel    <= limit_pkg::STOP_DYN_BRAKE;
      mon_reflect <= 1'b0;
    end else if (wr_en && idx == limit_pkg::IDX_CTRL && pstrb[0]) begin
      resp_sel    <= pwdata[limit_pkg::CTRL_RESP_LSB +: 2];
      stop_sel    <= pwdata[limit_pkg::CTRL_STOP_LSB +: 2];
      mon_reflect <= pwdata[limit_pkg::CTRL_MON_BIT];
    end
  end

  // torque saturates at the top of range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      estop_torque <= limit_pkg::ESTOP_TORQUE_USE_NORMAL;
    end else if (wr_en && idx == limit_pkg::IDX_ESTOP && pstrb[0]) begin
      if (pwdata[31:0] > {22'h0, limit_pkg::ESTOP_TORQUE_MAX}) begin
        estop_torque <= limit_pkg::ESTOP_TORQUE_MAX;
      end else begin
        estop_torque <= pwdata[9:0];
      end
    end
  end

  // Read data captured in setup so it is a flop in the access phase
  always_comb begin
    rd_val = 32'h0000_0000;
    if (idx <= limit_pkg::IDX_SEL_LAST) begin
      rd_val = selector[idx[2:0]];
    end else if (idx == limit_pkg::IDX_CTRL) begin
      rd_val = {27'h0, mon_reflect, stop_sel, resp_sel};
    end else if (idx == limit_pkg::IDX_ESTOP) begin
      rd_val = {22'h0, estop_torque};
    end else if (idx == limit_pkg::IDX_STATUS) begin
      rd_val = {25'h0, 2'(state), rev_blk, fwd_blk, alarm_active,
                rev_act, fwd_act};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (addr_ok && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= !addr_ok;
    end
  end

  // pick the byte for the active control mode
  always_comb begin
    for (int i = 0; i < N; i++) begin
      case (control_mode)
        limit_pkg::MODE_POS:    code[i] = selector[i][7:0];
        limit_pkg::MODE_SPEED:  code[i] = selector[i][15:8];
        limit_pkg::MODE_TORQUE: code[i] = selector[i][23:16];
        default:                code[i] = selector[i][7:0];
      endcase
    end
  end

  // active means switch actuated; NC open or NO shorted
  always_comb begin
    fwd_act  = 1'b0;
    rev_act  = 1'b0;
    is_limit = 8'h00;
    for (int i = 0; i < N; i++) begin
      if (code[i][6:0] == limit_pkg::FN_FWD_LIMIT) begin
        is_limit[i] = 1'b1;
        fwd_act = fwd_act | (code[i][limit_pkg::NC_BIT] ? !pins[i] : pins[i]);
      end
      if (code[i][6:0] == limit_pkg::FN_REV_LIMIT) begin
        is_limit[i] = 1'b1;
        rev_act = rev_act | (code[i][limit_pkg::NC_BIT] ? !pins[i] : pins[i]);
      end
    end
  end

  // directional blocking only in enabled mode
  assign fwd_blk = (resp_sel == limit_pkg::RESP_ENABLED) && fwd_act;
  assign rev_blk = (resp_sel == limit_pkg::RESP_ENABLED) && rev_act;

  // alarm conditions; mode 1 never alarms
  always_comb begin
    case (resp_sel)
      limit_pkg::RESP_ENABLED: alarm_set = fwd_act && rev_act;
      limit_pkg::RESP_ALARM:   alarm_set = fwd_act || rev_act;
      default:                 alarm_set = 1'b0;
    endcase
  end

  // Alarm is sticky; a new cause wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_active <= 1'b0;
    end else if (alarm_set) begin
      alarm_active <= 1'b1;
    end else if (alarm_clear) begin
      alarm_active <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_main <= 8'h00;
      alarm_sub  <= 4'h0;
    end else begin
      alarm_main <= (alarm_set || alarm_active) ? limit_pkg::ALARM_MAIN : 8'h00;
      alarm_sub  <= limit_pkg::ALARM_SUB;
    end
  end

  // permits; alarm stop takes over in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fwd_permit <= 1'b0;
      rev_permit <= 1'b0;
    end else begin
      fwd_permit <= !fwd_blk && !alarm_set && !alarm_active;
      rev_permit <= !rev_blk && !alarm_set && !alarm_active;
    end
  end

  // stop sequence runs while a direction is blocked
  assign stop_req = fwd_blk || rev_blk;
  assign slow     = motor_speed <= limit_pkg::STOP_SPEED_RPM;

  always_comb begin
    next_state = state;
    case (state)
      limit_pkg::ST_IDLE:  if (stop_req) next_state = limit_pkg::ST_DECEL;
      limit_pkg::ST_DECEL: if (slow) next_state = limit_pkg::ST_HOLD;
      limit_pkg::ST_HOLD:  if (!stop_req) next_state = limit_pkg::ST_IDLE;
      default:             next_state = limit_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= limit_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dyn_brake         <= 1'b0;
      free_run          <= 1'b0;
      estop_active      <= 1'b0;
      err_counter_clear <= 1'b0;
    end else begin
      dyn_brake    <= next_state == limit_pkg::ST_DECEL &&
                      stop_sel == limit_pkg::STOP_DYN_BRAKE;
      free_run     <= next_state == limit_pkg::ST_DECEL &&
                      stop_sel == limit_pkg::STOP_FREE_RUN;
      estop_active <= next_state == limit_pkg::ST_DECEL &&
                      stop_sel == limit_pkg::STOP_ESTOP;
      // Estop keeps the counter during decel, clears once on stopping
      err_counter_clear <= (next_state == limit_pkg::ST_DECEL &&
                            stop_sel != limit_pkg::STOP_ESTOP) ||
                           (state == limit_pkg::ST_DECEL &&
                            next_state == limit_pkg::ST_HOLD &&
                            stop_sel == limit_pkg::STOP_ESTOP);
    end
  end

  // estop torque, zero falls back to normal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_limit <= 10'h000;
    end else if (next_state == limit_pkg::ST_DECEL &&
                 stop_sel == limit_pkg::STOP_ESTOP &&
                 estop_torque != limit_pkg::ESTOP_TORQUE_USE_NORMAL) begin
      torque_limit <= estop_torque;
    end else begin
      torque_limit <= normal_torque_limit;
    end
  end

  // hide limit pins in ignore mode unless reflected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_monitor <= 8'h00;
    end else if (resp_sel == limit_pkg::RESP_IGNORE && !mon_reflect) begin
      io_monitor <= pins & ~is_limit;
    end else begin
      io_monitor <= pins;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  both_stop_a: assert property (
    resp_sel == limit_pkg::RESP_ENABLED && fwd_act && rev_act
    |=> !fwd_permit && !rev_permit)
    else $error("motion permitted with both limits off");
  fwd_block_a: assert property (
    resp_sel == limit_pkg::RESP_ENABLED && fwd_act && !rev_act && !alarm_active
    |=> !fwd_permit && rev_permit)
    else $error("forward limit did not block forward only");
  rev_block_a: assert property (
    resp_sel == limit_pkg::RESP_ENABLED && rev_act && !fwd_act && !alarm_active
    |=> fwd_permit && !rev_permit)
    else $error("reverse limit did not block reverse only");
  both_alarm_a: assert property (
    resp_sel == limit_pkg::RESP_ENABLED && fwd_act && rev_act
    |=> alarm_active && alarm_main == limit_pkg::ALARM_MAIN)
    else $error("no alarm with both limits open");
  ignore_mode_a: assert property (
    resp_sel == limit_pkg::RESP_IGNORE && !alarm_active && !alarm_set
    |=> fwd_permit && rev_permit)
    else $error("limits not ignored in mode 1");
  either_alarm_a: assert property (
    resp_sel == limit_pkg::RESP_ALARM && (fwd_act || rev_act) |=> alarm_active)
    else $error("no alarm in mode 2 with a limit open");
  decel_end_a: assert property (
    state == limit_pkg::ST_DECEL && slow |=> state == limit_pkg::ST_HOLD)
    else $error("deceleration did not end at stop speed");
  estop_torque_a: assert property (
    estop_active && $past(estop_torque) != limit_pkg::ESTOP_TORQUE_USE_NORMAL
    |-> torque_limit == $past(estop_torque))
    else $error("estop torque limit not applied");
  method_excl_a: assert property (
    $rose(state == limit_pkg::ST_DECEL) && $past(stop_sel) == limit_pkg::STOP_FREE_RUN
    |-> free_run && !dyn_brake && !estop_active)
    else $error("wrong deceleration method");
endmodule
`default_nettype wire

// >>> rtl/sync_bit.sv
// Two-stage synchroniser for one input bit
`timescale 1ns/10ps
`default_nettype none
module sync_bit (
  input  wire logic pclk,     // Clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic d,        // Asynchronous level
  output var  logic q         // Synchronised level
);
  logic meta;

  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/drive_limit_prohibit_logic_tb.sv
// Self-checking bench for the drive limit prohibition logic
`timescale 1ns/10ps
`default_nettype none
module drive_limit_prohibit_logic_tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  input_pins;
  logic [1:0]  control_mode = 2'h0;
  logic [15:0] motor_speed = 16'h0064;
  logic [9:0]  normal_torque_limit = 10'h064;
  logic        alarm_clear = 1'b0;
  logic        fwd_permit, rev_permit, dyn_brake, free_run, estop_active;
  logic        err_counter_clear, alarm_active;
  logic [9:0]  torque_limit;
  logic [7:0]  alarm_main, io_monitor;
  logic [3:0]  alarm_sub;
  logic        fwd_open = 1'b0;
  logic        rev_open = 1'b0;
  logic [7:0]  other_pins = 8'h00;
  logic [31:0] rd, rnd;
  logic        er;
  logic [9:0]  est;
  int          errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  integer      seed = 32'h6592;

  always #5 pclk = ~pclk;

  drive_limit_prohibit_logic dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .input_pins(input_pins),
    .control_mode(control_mode), .motor_speed(motor_speed),
    .normal_torque_limit(normal_torque_limit), .alarm_clear(alarm_clear),
    .fwd_permit(fwd_permit), .rev_permit(rev_permit), .dyn_brake(dyn_brake),
    .free_run(free_run), .estop_active(estop_active), .err_counter_clear(err_counter_clear),
    .torque_limit(torque_limit), .alarm_active(alarm_active), .alarm_main(alarm_main),
    .alarm_sub(alarm_sub), .io_monitor(io_monitor));

  limit_switch_model sw_u (.fwd_open(fwd_open), .rev_open(rev_open),
    .other_pins(other_pins), .input_pins(input_pins));

  // Expected {forward, reverse} permits per response select
  function automatic logic [1:0] exp_permit(input logic [1:0] resp, input logic fo,
                                            input logic ro);
    if (resp == limit_pkg::RESP_ENABLED) return (fo && ro) ? 2'h0 : {~fo, ~ro};
    if (resp == limit_pkg::RESP_ALARM) return (fo || ro) ? 2'h0 : 2'h3;
    return 2'h3;
  endfunction

  // Expected {brake, coast, estop} while decelerating
  function automatic logic [2:0] exp_stop(input logic [1:0] m);
    return {m == limit_pkg::STOP_DYN_BRAKE, m == limit_pkg::STOP_FREE_RUN,
            m == limit_pkg::STOP_ESTOP};
  endfunction

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready, no assumed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Outputs sampled mid-cycle, clear of edge updates
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic set_pins(input logic fo, input logic ro, input int n);
    @(posedge pclk);
    fwd_open <= fo;
    rev_open <= ro;
    settle(n);
  endtask

  task automatic clear_alarm();
    @(posedge pclk);
    alarm_clear <= 1'b1;
    @(posedge pclk);
    alarm_clear <= 1'b0;
    settle(2);
    chk(32'(alarm_active), 32'h0);
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    other_pins = 8'($random(seed));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, (i == 1) ? limit_pkg::SEL_TWO_RST : (i == 2) ? limit_pkg::SEL_THREE_RST : limit_pkg::SEL_OTHER_RST);
    end
    rnd = $random(seed);
    apb(1'b1, 12'h01c, rnd);
    apb(1'b0, 12'h01c, 32'h0);
    chk(rd, rnd);
    // Random codes could claim a limit function on pin 7
    apb(1'b1, 12'h01c, 32'h0);
    apb(1'b0, 12'h02c, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, limit_pkg::OFS_ESTOP, 32'h0000_0258);
    apb(1'b0, limit_pkg::OFS_ESTOP, 32'h0);
    chk(rd, 32'(limit_pkg::ESTOP_TORQUE_MAX));
    // Limits ignored out of reset
    set_pins(1'b1, 1'b1, 5);
    chk({fwd_permit, rev_permit, alarm_active}, 32'h6);
    set_pins(1'b0, 1'b0, 5);
    chk(32'(io_monitor[2:1]), 32'h0);
    // Still mode 1, reflect now set
    apb(1'b1, limit_pkg::OFS_CTRL, 32'h0000_0011);
    settle(2);
    chk(io_monitor, {other_pins[7:3], 2'h3, other_pins[0]});
    for (int m = 0; m < 3; m++) begin
      for (int d = 0; d < 2; d++) begin
        est = (m == 2 && d == 1) ? 10'h000 : 10'($unsigned($random(seed)) % 500 + 1);
        apb(1'b1, limit_pkg::OFS_ESTOP, 32'(est));
        apb(1'b1, limit_pkg::OFS_CTRL, {28'h0, 2'(m), limit_pkg::RESP_ENABLED});
        @(posedge pclk);
        motor_speed <= 16'($unsigned($random(seed)) % 1000 + 31);
        normal_torque_limit <= 10'($unsigned($random(seed)) % 501);
        control_mode <= 2'($unsigned($random(seed)) % 3);
        set_pins(d == 0, d == 1, 1);
        chk({fwd_permit, rev_permit}, 32'h3);
        settle(4);
        chk({fwd_permit, rev_permit}, exp_permit(2'h0, d == 0, d == 1));
        chk({dyn_brake, free_run, estop_active}, exp_stop(2'(m)));
        chk(32'(err_counter_clear), 32'(m != 2));
        chk(32'(torque_limit), 32'((m == 2 && est != 10'h0) ? est : normal_torque_limit));
        apb(1'b0, limit_pkg::OFS_STATUS, 32'h0);
        chk({rd[6:5], rd[1:0]}, {2'h1, d == 1, d == 0});
        @(posedge pclk);
        motor_speed <= 16'h001e;
        settle(1);
        // Estop clears the error counter once, on stopping
        chk(32'(err_counter_clear), 32'(m == 2));
        settle(1);
        apb(1'b0, limit_pkg::OFS_STATUS, 32'h0);
        chk(32'(rd[6:5]), 32'h2);
        chk({dyn_brake, free_run, estop_active}, 32'h0);
        chk(32'(err_counter_clear), 32'h0);
        set_pins(1'b0, 1'b0, 5);
        chk({fwd_permit, rev_permit, alarm_active}, 32'h6);
        apb(1'b0, limit_pkg::OFS_STATUS, 32'h0);
        chk({rd[6:5], rd[1:0]}, 32'h0);
      end
    end
    set_pins(1'b1, 1'b1, 5);
    chk({fwd_permit, rev_permit, alarm_active, alarm_main}, {3'h1, limit_pkg::ALARM_MAIN});
    set_pins(1'b0, 1'b0, 4);
    // Alarm outlives its cause until cleared
    chk({fwd_permit, rev_permit, alarm_active}, 32'h1);
    clear_alarm();
    apb(1'b1, limit_pkg::OFS_CTRL, {30'h0, limit_pkg::RESP_ALARM});
    for (int d = 0; d < 2; d++) begin
      set_pins(d == 0, d == 1, 5);
      chk({fwd_permit, rev_permit, alarm_active, alarm_main}, {3'h1, limit_pkg::ALARM_MAIN});
      chk(32'(alarm_sub), 32'(limit_pkg::ALARM_SUB));
      set_pins(1'b0, 1'b0, 4);
      clear_alarm();
    end
    end_sim();
  end
endmodule
`default_nettype wire

// >>> testbench/limit_switch_model.sv
// Limit switch pair at the two axis ends, wired normally closed
`timescale 1ns/10ps
`default_nettype none
module limit_switch_model (
  input  wire logic       fwd_open,    // Forward end switch actuated
  input  wire logic       rev_open,    // Reverse end switch actuated
  input  wire logic [7:0] other_pins,  // Levels of unrelated inputs
  output logic      [7:0] input_pins   // Pin levels, 1 = contact shorted
);
  // Forward on pin 1, reverse on pin 2
  // Actuated NC contact opens, so the pin reads 0
  assign input_pins = {other_pins[7:3], ~rev_open, ~fwd_open, other_pins[0]};
endmodule
`default_nettype wire
